// file: lsse_exec.sv
// Execution unit for data transfer, stack, I/O bit and shift instructions
// Summary of operation
// [RULE1] Post-increment load reads, then bumps pointer; two cycles
// [RULE2] Pre-decrement load drops pointer, then reads; two cycles
// [RULE3] Displaced load uses pointer b/c plus offset
// [RULE4] Direct load reads absolute address; two cycles
// [RULE5] Post-increment write stores, then bumps pointer; two cycles
// [RULE6] Pre-decrement write drops pointer, then stores; two cycles
// [RULE7] Displaced write uses pointer b/c plus offset
// [RULE8] Direct write stores to absolute address; two cycles
// [RULE9] Program memory read via pointer c; three cycles
// [RULE10] Stack save writes register; two cycles, no flags
// [RULE11] Stack restore loads register; two cycles, no flags
// [RULE12] I/O bit set forces one bit high
// [RULE13] I/O bit clear forces one bit low
// [RULE14] Left shift fills zero, updates Z C N V
// [RULE15] Right shift fills zero, updates Z C N V
// [RULE16] Left rotate moves carry in at bit 0
// [RULE17] Right rotate moves carry in at bit 7
// [RULE18] Arithmetic right shift keeps sign bit
// [RULE19] Nibble exchange swaps halves, no flags
// [RULE20] Transfers leave every status flag unchanged
// [RULE21] Load into its own pointer is undefined
`timescale 1ns/1ps
`default_nettype none
`include "lsse_map.svh"

module lsse_exec
	import lsse_pkg::*;
(
	input  wire logic        ref_clk_in,     // System clock, 40 MHz
	input  wire logic        rst_in,         // Synchronous reset, active high
	input  wire logic        cmd_valid_in,   // Decoded instruction present
	input  wire lsse_op_t    cmd_op_in,      // Operation
	input  wire lsse_amode_t cmd_amode_in,   // Pointer addressing form
	input  wire logic [1:0]  cmd_ptr_in,     // Pointer pair select a/b/c
	input  wire logic [4:0]  cmd_rd_in,      // Destination register
	input  wire logic [4:0]  cmd_rr_in,      // Source register
	input  wire logic [5:0]  cmd_disp_in,    // Displacement
	input  wire logic [15:0] cmd_addr_in,    // Absolute data address
	input  wire logic [7:0]  cmd_imm_in,     // Immediate constant
	input  wire logic [5:0]  cmd_io_in,      // I/O register address
	input  wire logic [2:0]  cmd_bit_in,     // I/O bit number
	output logic             cmd_ready_out,  // Unit can take an instruction
	output logic             done_out,       // Instruction finished pulse
	output logic [15:0]      dmem_addr_out,  // Data memory address
	output logic [7:0]       dmem_wdata_out, // Data memory write data
	output logic             dmem_re_out,    // Data memory read strobe
	output logic             dmem_we_out,    // Data memory write strobe
	input  wire logic [7:0]  dmem_rdata_in,  // Data memory read data
	output logic [15:0]      pmem_addr_out,  // Program memory byte address
	output logic             pmem_re_out,    // Program memory read strobe
	input  wire logic [7:0]  pmem_rdata_in,  // Program memory read data
	output logic [5:0]       io_addr_out,    // I/O register address
	output logic             io_re_out,      // I/O read strobe
	output logic             io_we_out,      // I/O write strobe
	output logic [7:0]       io_wdata_out,   // I/O write data
	input  wire logic [7:0]  io_rdata_in,    // I/O read data
	output logic [7:0]       sreg_out,       // Status flags
	output logic [15:0]      sp_out,         // Stack pointer
	input  wire logic [4:0]  dbg_sel_in,     // Register file peek select
	output logic [7:0]       dbg_data_out    // Register file peek data
);

	logic [7:0]  regs [0:31];
	lsse_state_t state_q;
	logic        ready_q;
	logic        done_q;
	logic [15:0] dmem_addr_q;
	logic [7:0]  dmem_wdata_q;
	logic        dmem_re_q;
	logic        dmem_we_q;
	logic [15:0] pmem_addr_q;
	logic        pmem_re_q;
	logic [5:0]  io_addr_q;
	logic        io_re_q;
	logic        io_we_q;
	logic [7:0]  io_wdata_q;
	logic [7:0]  sreg_q;
	logic [15:0] sp_q;
	logic [7:0]  dbg_q;
	logic        ld_pend_q;
	logic        ld_pm_q;
	logic [4:0]  ld_dst_q;
	logic        io_pend_q;
	logic        io_set_q;
	logic [2:0]  bit_q;

	assign cmd_ready_out  = ready_q;
	assign done_out       = done_q;
	assign dmem_addr_out  = dmem_addr_q;
	assign dmem_wdata_out = dmem_wdata_q;
	assign dmem_re_out    = dmem_re_q;
	assign dmem_we_out    = dmem_we_q;
	assign pmem_addr_out  = pmem_addr_q;
	assign pmem_re_out    = pmem_re_q;
	assign io_addr_out    = io_addr_q;
	assign io_re_out      = io_re_q;
	assign io_we_out      = io_we_q;
	assign io_wdata_out   = io_wdata_q;
	assign sreg_out       = sreg_q;
	assign sp_out         = sp_q;
	assign dbg_data_out   = dbg_q;

	// Instruction classes
	wire accept    = cmd_valid_in & ready_q;
	wire is_ld_ind = (cmd_op_in == LSSE_OP_IND_LOAD);
	wire is_st_ind = (cmd_op_in == LSSE_OP_IND_WRITE);
	wire is_ld_dir = (cmd_op_in == LSSE_OP_DIR_LOAD);
	wire is_st_dir = (cmd_op_in == LSSE_OP_DIR_WRITE);
	wire is_push   = (cmd_op_in == LSSE_OP_PUSH);
	wire is_pop    = (cmd_op_in == LSSE_OP_POP);
	wire is_pm     = (cmd_op_in == LSSE_OP_PM_DEF) | (cmd_op_in == LSSE_OP_PM_READ)
		| (cmd_op_in == LSSE_OP_PM_INC);
	wire is_ioset  = (cmd_op_in == LSSE_OP_IO_SET);
	wire is_ioclr  = (cmd_op_in == LSSE_OP_IO_CLR);
	wire is_iobit  = is_ioset | is_ioclr;
	wire is_lsl    = (cmd_op_in == LSSE_OP_LSL);
	wire is_lsr    = (cmd_op_in == LSSE_OP_LSR);
	wire is_rol    = (cmd_op_in == LSSE_OP_ROL);
	wire is_ror    = (cmd_op_in == LSSE_OP_ROR);
	wire is_asr    = (cmd_op_in == LSSE_OP_ASR);
	wire is_swap   = (cmd_op_in == LSSE_OP_SWAP);
	wire is_shift  = is_lsl | is_lsr | is_rol | is_ror | is_asr;
	wire is_dload  = is_ld_ind | is_ld_dir | is_pop;
	wire is_dwrite = is_st_ind | is_st_dir | is_push;
	wire is_multi  = is_dload | is_dwrite | is_pm | is_iobit;

	// Pointer pair selection; program memory always goes through pair c
	wire [1:0] psel    = is_pm ? `LSSE_PSEL_C : cmd_ptr_in;
	wire [4:0] ptr_lo  = (psel == `LSSE_PSEL_A) ? `LSSE_PTR_A_LO
		: (psel == `LSSE_PSEL_B) ? `LSSE_PTR_B_LO : `LSSE_PTR_C_LO;
	wire [4:0] ptr_hi  = ptr_lo | `LSSE_PAIR_HI_BIT;
	wire [15:0] ptr_val = {regs[ptr_hi], regs[ptr_lo]};
	wire [15:0] ptr_inc = ptr_val + `LSSE_ONE16;
	wire [15:0] ptr_dec = ptr_val - `LSSE_ONE16;
	wire [15:0] ptr_dsp = ptr_val + {10'h000, cmd_disp_in};

	wire am_post = (cmd_amode_in == LSSE_AM_POSTINC);
	wire am_pre  = (cmd_amode_in == LSSE_AM_PREDEC);
	wire am_disp = (cmd_amode_in == LSSE_AM_DISP) & (psel != `LSSE_PSEL_A);

	// Effective data address
	wire [15:0] ind_addr = am_pre ? ptr_dec : (am_disp ? ptr_dsp : ptr_val); // RULE2 RULE3 RULE6 RULE7
	wire [15:0] sp_inc   = sp_q + `LSSE_ONE16;
	wire [15:0] sp_dec   = sp_q - `LSSE_ONE16;
	wire [15:0] mem_addr = (is_ld_dir | is_st_dir) ? cmd_addr_in // RULE4 RULE8
		: is_push ? sp_q
		: is_pop ? sp_inc
		: ind_addr;

	// Pointer write-back for auto-modified forms
	wire ptr_post = ((is_ld_ind | is_st_ind) & am_post) | (cmd_op_in == LSSE_OP_PM_INC);
	wire ptr_pre  = (is_ld_ind | is_st_ind) & am_pre;
	wire ptr_wr   = accept & (ptr_post | ptr_pre);
	wire [15:0] ptr_new = ptr_pre ? ptr_dec : ptr_inc; // RULE1 RULE2 RULE5 RULE6 RULE9

	// Load destination
	wire [4:0] ld_dst = (cmd_op_in == LSSE_OP_PM_DEF) ? `LSSE_DEF_TARGET : cmd_rd_in; // RULE9

	// Shift and rotate unit
	wire [7:0] rd_val = regs[cmd_rd_in];
	wire       c_old  = sreg_q[`LSSE_FLAG_C];
	wire [7:0] sh_res = is_lsl ? {rd_val[6:0], 1'b0} // RULE14
		: is_lsr ? {1'b0, rd_val[7:1]}             // RULE15
		: is_rol ? {rd_val[6:0], c_old}            // RULE16
		: is_ror ? {c_old, rd_val[7:1]}            // RULE17
		: is_asr ? {rd_val[7], rd_val[7:1]}        // RULE18
		: {rd_val[3:0], rd_val[7:4]};              // RULE19
	wire       sh_c   = (is_lsl | is_rol) ? rd_val[7] : rd_val[0];
	wire       sh_n   = sh_res[7];
	wire       sh_z   = (sh_res == `LSSE_BYTE_RESET);
	wire       sh_v   = sh_n ^ sh_c;

	// Read-modify-write of the addressed I/O bit
	wire [7:0] io_mask = `LSSE_BIT0_MASK << bit_q;
	wire [7:0] io_mod  = io_set_q ? (io_rdata_in | io_mask) : (io_rdata_in & ~io_mask);

	wire [7:0] ld_data = ld_pm_q ? pmem_rdata_in : dmem_rdata_in;
	wire       in_last = (state_q == LSSE_ST_LAST);

	// Register file; load write-back lands after any pointer update
	always_ff @(posedge ref_clk_in)
	begin
		if (accept)
		begin
			if (cmd_op_in == LSSE_OP_REG_COPY)
			begin
				regs[cmd_rd_in] <= regs[cmd_rr_in]; // RULE20
			end
			else if (cmd_op_in == LSSE_OP_PAIR_COPY)
			begin
				regs[{cmd_rd_in[4:1], 1'b0}] <= regs[{cmd_rr_in[4:1], 1'b0}]; // RULE20
				regs[{cmd_rd_in[4:1], 1'b1}] <= regs[{cmd_rr_in[4:1], 1'b1}];
			end
			else if (cmd_op_in == LSSE_OP_IMM_LOAD)
			begin
				regs[cmd_rd_in] <= cmd_imm_in; // RULE20
			end
			else if (is_shift | is_swap)
			begin
				regs[cmd_rd_in] <= sh_res;
			end
			if (ptr_wr)
			begin
				regs[ptr_lo] <= ptr_new[7:0];
				regs[ptr_hi] <= ptr_new[15:8];
			end
		end
		if (in_last & ld_pend_q)
		begin
			regs[ld_dst_q] <= ld_data; // RULE11 RULE21
		end
	end

	// Sequencer, memory strobes and architectural state
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			state_q      <= LSSE_ST_IDLE;
			ready_q      <= 1'b0;
			done_q       <= 1'b0;
			dmem_addr_q  <= `LSSE_ADDR_RESET;
			dmem_wdata_q <= `LSSE_BYTE_RESET;
			dmem_re_q    <= 1'b0;
			dmem_we_q    <= 1'b0;
			pmem_addr_q  <= `LSSE_ADDR_RESET;
			pmem_re_q    <= 1'b0;
			io_addr_q    <= `LSSE_IO_RESET;
			io_re_q      <= 1'b0;
			io_we_q      <= 1'b0;
			io_wdata_q   <= `LSSE_BYTE_RESET;
			sreg_q       <= `LSSE_SREG_RESET;
			sp_q         <= `LSSE_SP_RESET;
			dbg_q        <= `LSSE_BYTE_RESET;
			ld_pend_q    <= 1'b0;
			ld_pm_q      <= 1'b0;
			ld_dst_q     <= `LSSE_REG_RESET;
			io_pend_q    <= 1'b0;
			io_set_q     <= 1'b0;
			bit_q        <= `LSSE_BIT_RESET;
		end
		else
		begin
			done_q    <= 1'b0;
			dmem_re_q <= 1'b0;
			dmem_we_q <= 1'b0;
			pmem_re_q <= 1'b0;
			io_re_q   <= 1'b0;
			io_we_q   <= 1'b0;
			dbg_q     <= regs[dbg_sel_in];
			case (state_q)
				LSSE_ST_IDLE:
				begin
					ready_q <= 1'b1;
					if (accept)
					begin
						ld_pend_q <= is_dload | is_pm;
						ld_pm_q   <= is_pm;
						ld_dst_q  <= ld_dst;
						io_pend_q <= is_iobit;
						io_set_q  <= is_ioset;
						bit_q     <= cmd_bit_in;
						if (is_multi)
						begin
							ready_q <= 1'b0;
							state_q <= is_pm ? LSSE_ST_PWAIT : LSSE_ST_LAST; // RULE9
						end
						else
						begin
							done_q <= 1'b1;
						end
						if (is_dload | is_dwrite)
						begin
							dmem_addr_q  <= mem_addr; // RULE1 RULE4 RULE5 RULE8
							dmem_re_q    <= is_dload;
							dmem_we_q    <= is_dwrite; // RULE10
							dmem_wdata_q <= regs[cmd_rr_in];
						end
						if (is_pm)
						begin
							pmem_addr_q <= ptr_val; // RULE9
							pmem_re_q   <= 1'b1;
						end
						if (is_push)
						begin
							sp_q <= sp_dec; // RULE10
						end
						else if (is_pop)
						begin
							sp_q <= sp_inc; // RULE11
						end
						if (is_iobit)
						begin
							io_addr_q <= cmd_io_in; // RULE12 RULE13
							io_re_q   <= 1'b1;
						end
						else if (cmd_op_in == LSSE_OP_IO_OUT)
						begin
							io_addr_q  <= cmd_io_in; // RULE20
							io_we_q    <= 1'b1;
							io_wdata_q <= regs[cmd_rr_in];
						end
						if (is_shift)
						begin
							sreg_q[`LSSE_FLAG_C] <= sh_c; // RULE14 RULE15 RULE16 RULE17 RULE18
							sreg_q[`LSSE_FLAG_Z] <= sh_z;
							sreg_q[`LSSE_FLAG_N] <= sh_n;
							sreg_q[`LSSE_FLAG_V] <= sh_v;
						end
					end
				end
				LSSE_ST_PWAIT:
				begin
					state_q <= LSSE_ST_LAST;
				end
				LSSE_ST_LAST:
				begin
					state_q   <= LSSE_ST_IDLE;
					ready_q   <= 1'b1;
					done_q    <= 1'b1;
					ld_pend_q <= 1'b0;
					io_pend_q <= 1'b0;
					if (io_pend_q)
					begin
						io_we_q    <= 1'b1; // RULE12 RULE13
						io_wdata_q <= io_mod;
					end
				end
				default:
				begin
					state_q <= LSSE_ST_IDLE;
					ready_q <= 1'b1;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// file: lsse_exec_props.sv
// Port assertions for the execution unit
`timescale 1ns/1ps
`default_nettype none
module lsse_exec_props
	import lsse_pkg::*;
(
	input wire logic       ref_clk_in,    // Clock
	input wire logic       rst_in,        // Reset
	input wire logic       cmd_valid_in,  // Request
	input wire lsse_op_t   cmd_op_in,     // Operation
	input wire logic [2:0] cmd_bit_in,    // Bit number
	input wire logic       cmd_ready_out, // Ready
	input wire logic       done_out,      // Done
	input wire logic       dmem_re_out,   // Data read
	input wire logic       dmem_we_out,   // Data write
	input wire logic       pmem_re_out,   // Program read
	input wire logic       io_re_out,     // I/O read
	input wire logic       io_we_out,     // I/O write
	input wire logic [7:0] io_wdata_out,  // I/O data out
	input wire logic [7:0] io_rdata_in,   // I/O data in
	input wire logic [7:0] sreg_out       // Flags
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	wire tk = cmd_valid_in && cmd_ready_out;
	sequence s_fin; !cmd_ready_out ##1 done_out; endsequence
	sequence s_kept; $stable(sreg_out) [*2]; endsequence
	chk_load_steps:
	assert property (tk && cmd_op_in inside {LSSE_OP_IND_LOAD, LSSE_OP_DIR_LOAD}
		|-> ##1 dmem_re_out ##0 s_fin) else $error("load timing wrong");
	chk_write_steps:
	assert property (tk && cmd_op_in inside {LSSE_OP_IND_WRITE, LSSE_OP_DIR_WRITE}
		|-> ##1 dmem_we_out ##0 s_fin) else $error("write timing wrong");
	chk_pm_steps:
	assert property (tk && cmd_op_in inside {LSSE_OP_PM_DEF, LSSE_OP_PM_READ, LSSE_OP_PM_INC}
		|-> ##1 pmem_re_out ##1 s_fin) else $error("program read timing wrong");
	chk_stack_flags:
	assert property (tk && cmd_op_in inside {LSSE_OP_PUSH, LSSE_OP_POP}
		|-> ##1 s_kept ##0 done_out) else $error("stack step wrong");
	chk_io_set:
	assert property (tk && cmd_op_in == LSSE_OP_IO_SET |-> ##1 io_re_out ##1 io_we_out
		&& io_wdata_out == ($past(io_rdata_in) | 8'h01 << $past(cmd_bit_in, 2)))
		else $error("bit set wrong");
	chk_io_clr:
	assert property (tk && cmd_op_in == LSSE_OP_IO_CLR |-> ##1 io_re_out ##1 io_we_out
		&& io_wdata_out == ($past(io_rdata_in) & ~(8'h01 << $past(cmd_bit_in, 2))))
		else $error("bit clear wrong");
	chk_shift_one:
	assert property (tk && cmd_op_in inside {[LSSE_OP_LSL:LSSE_OP_ASR]}
		|-> ##1 done_out && cmd_ready_out) else $error("shift not one cycle");
	chk_swap_flags:
	assert property (tk && cmd_op_in == LSSE_OP_SWAP |-> ##1 done_out && $stable(sreg_out))
		else $error("swap changed flags");
endmodule
bind lsse_exec lsse_exec_props i_props (.ref_clk_in, .rst_in, .cmd_valid_in, .cmd_op_in,
	.cmd_bit_in, .cmd_ready_out, .done_out, .dmem_re_out, .dmem_we_out, .pmem_re_out,
	.io_re_out, .io_we_out, .io_wdata_out, .io_rdata_in, .sreg_out);
`default_nettype wire

// file: lsse_exec_tb_top.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module lsse_exec_tb_top
	import lsse_pkg::*;
;
	logic        ref_clk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0;
	lsse_op_t    cmd_op_in = LSSE_OP_NOP;
	lsse_amode_t cmd_amode_in = LSSE_AM_PLAIN;
	logic [1:0]  cmd_ptr_in = 2'h0;
	logic [4:0]  cmd_rd_in = 5'h00, cmd_rr_in = 5'h00, dbg_sel_in = 5'h00;
	logic [5:0]  cmd_disp_in = 6'h00, cmd_io_in = 6'h00;
	logic [15:0] cmd_addr_in = 16'h0000;
	logic [7:0]  cmd_imm_in = 8'h00;
	logic [2:0]  cmd_bit_in = 3'h0;
	wire logic        cmd_ready_out, done_out, dmem_re_out, dmem_we_out, pmem_re_out;
	wire logic        io_re_out, io_we_out;
	wire logic [5:0]  io_addr_out;
	wire logic [15:0] dmem_addr_out, pmem_addr_out, sp_out;
	wire logic [7:0]  dmem_wdata_out, dmem_rdata_in, pmem_rdata_in, io_wdata_out;
	wire logic [7:0]  io_rdata_in, sreg_out, dbg_data_out;
	int          fail_count = 0, checked = 0, cyc = 0;
	lsse_exec i_dut (.ref_clk_in, .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_amode_in,
		.cmd_ptr_in, .cmd_rd_in, .cmd_rr_in, .cmd_disp_in, .cmd_addr_in, .cmd_imm_in,
		.cmd_io_in, .cmd_bit_in, .cmd_ready_out, .done_out, .dmem_addr_out,
		.dmem_wdata_out, .dmem_re_out, .dmem_we_out, .dmem_rdata_in, .pmem_addr_out,
		.pmem_re_out, .pmem_rdata_in, .io_addr_out, .io_re_out, .io_we_out,
		.io_wdata_out, .io_rdata_in, .sreg_out, .sp_out, .dbg_sel_in, .dbg_data_out);
	lsse_mem_model i_mem (.clk_in(ref_clk_in), .d_addr_in(dmem_addr_out),
		.d_wdata_in(dmem_wdata_out), .d_re_in(dmem_re_out), .d_we_in(dmem_we_out),
		.d_rdata_out(dmem_rdata_in), .p_addr_in(pmem_addr_out), .p_re_in(pmem_re_out),
		.p_rdata_out(pmem_rdata_in), .i_addr_in(io_addr_out), .i_re_in(io_re_out),
		.i_we_in(io_we_out), .i_wdata_in(io_wdata_out), .i_rdata_out(io_rdata_in));
	initial forever #12.5 ref_clk_in = ~ref_clk_in;
	task automatic check(input string nm, input logic [15:0] seen, exp);
		checked++;
		fail_count += int'(seen !== exp);
		if (seen !== exp)
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
	endtask
	task automatic report_and_stop;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			fail_count++;
			report_and_stop();
		end
	end
	function automatic int ncyc(input lsse_op_t o);
		if (o inside {LSSE_OP_PM_DEF, LSSE_OP_PM_READ, LSSE_OP_PM_INC})
			return 3;
		return (o inside {LSSE_OP_REG_COPY, LSSE_OP_PAIR_COPY, LSSE_OP_IMM_LOAD,
			LSSE_OP_IO_OUT} || o >= LSSE_OP_LSL) ? 1 : 2;
	endfunction
	// Expected {flags, result} of a shift given the flags before it
	function automatic logic [15:0] shm(input lsse_op_t o, input logic [7:0] v, f);
		logic [7:0] r;
		logic       c;
		case (o)
			LSSE_OP_LSL: {c, r} = {v, 1'b0};
			LSSE_OP_LSR: {r, c} = {1'b0, v};
			LSSE_OP_ROL: {c, r} = {v, f[0]};
			LSSE_OP_ROR: {r, c} = {f[0], v};
			LSSE_OP_ASR: {r, c} = {v[7], v};
			default: return {f, v[3:0], v[7:4]};
		endcase
		return {4'h0, r[7] ^ c, r[7], r == 8'h00, c, r};
	endfunction
	task automatic run(input lsse_op_t o, input int m, p, d, s, input logic [15:0] v);
		int k;
		k = 0;
		@(posedge ref_clk_in);
		cmd_valid_in <= 1'b1;
		cmd_op_in <= o;
		cmd_amode_in <= lsse_amode_t'(m);
		cmd_ptr_in <= 2'(p);
		cmd_rd_in <= 5'(d);
		cmd_rr_in <= 5'(s);
		cmd_addr_in <= v;
		cmd_imm_in <= v[7:0];
		cmd_disp_in <= v[5:0];
		cmd_io_in <= v[5:0];
		cmd_bit_in <= v[10:8];
		do @(posedge ref_clk_in); while (cmd_ready_out !== 1'b1 && k++ < 9);
		cmd_valid_in <= 1'b0;
		// Done stands only in the last cycle, N-1 edges after the take
		repeat (ncyc(o) - 1) @(posedge ref_clk_in);
		#1 check("done", done_out, 1'b1);
	endtask
	task automatic peek(input int r, output logic [7:0] v);
		@(posedge ref_clk_in);
		dbg_sel_in <= 5'(r);
		repeat (2) @(posedge ref_clk_in);
		v = dbg_data_out;
	endtask
	task automatic pair(input int p, output logic [15:0] v);
		peek(26 + 2 * p, v[7:0]);
		peek(27 + 2 * p, v[15:8]);
	endtask
	task automatic setp(input int p, input logic [15:0] v);
		run(LSSE_OP_IMM_LOAD, 0, 0, 26 + 2 * p, 0, {8'h00, v[7:0]});
		run(LSSE_OP_IMM_LOAD, 0, 0, 27 + 2 * p, 0, {8'h00, v[15:8]});
	endtask
	initial
	begin
		logic [15:0] pv, ea, ep, q, x;
		logic [7:0]  d, v, f;
		lsse_op_t    o;
		void'($urandom(32'h4129));
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		d = 8'($urandom);
		run(LSSE_OP_IMM_LOAD, 0, 0, 16, 0, {8'h00, d});
		for (int p = 0; p < 3; p++)
			for (int m = 0; m < 4; m++)
			begin
				pv = 16'($urandom);
				q = 16'($urandom % 64);
				ea = m == 2 ? pv - 16'h0001 : (m == 3 && p != 0) ? pv + q : pv;
				ep = m == 1 ? pv + 16'h0001 : m == 2 ? pv - 16'h0001 : pv;
				setp(p, pv);
				run(LSSE_OP_IND_WRITE, m, p, 0, 16, q);
				check("store", i_mem.dmem[ea], d);
				pair(p, x);
				check("store ptr", x, ep);
				setp(p, pv);
				run(LSSE_OP_IND_LOAD, m, p, 17, 0, q);
				peek(17, v);
				check("load", v, d);
				pair(p, x);
				check("load ptr", x, ep);
			end
		x = 16'($urandom);
		run(LSSE_OP_DIR_WRITE, 0, 0, 0, 16, x);
		check("direct store", i_mem.dmem[x], d);
		run(LSSE_OP_DIR_LOAD, 0, 0, 18, 0, x);
		peek(18, v);
		check("direct load", v, d);
		pv = 16'($urandom);
		setp(2, pv);
		for (int k = 0; k < 3; k++)
		begin
			run(lsse_op_t'(8 + k), 0, 0, 20, 0, 0);
			peek(k == 0 ? 0 : 20, v);
			check("program read", v, pv[7:0] ^ pv[15:8] ^ 8'h5A);
		end
		pair(2, x);
		check("program ptr", x, pv + 16'h0001);
		run(LSSE_OP_PUSH, 0, 0, 0, 16, 0);
		check("push", i_mem.dmem[0], d);
		check("push sp", sp_out, 16'hFFFF);
		run(LSSE_OP_POP, 0, 0, 19, 0, 0);
		peek(19, v);
		check("pop", v, d);
		check("pop sp", sp_out, 16'h0000);
		for (int k = 0; k < 4; k++)
		begin
			x = 16'($urandom % 2048);
			v = 8'($urandom);
			run(LSSE_OP_IMM_LOAD, 0, 0, 16, 0, {8'h00, v});
			run(LSSE_OP_IO_OUT, 0, 0, 0, 16, x);
			run(k[0] ? LSSE_OP_IO_CLR : LSSE_OP_IO_SET, 0, 0, 0, 0, x);
			f = k[0] ? v & ~(8'h01 << x[10:8]) : v | (8'h01 << x[10:8]);
			// The modified byte is written at the edge that ends the done cycle
			#25;
			check("io bit", i_mem.io[x[5:0]], f);
		end
		check("flags kept", sreg_out, 8'h00);
		f = 8'h00;
		for (int k = 0; k < 14; k++)
		begin
			v = k == 6 ? 8'h00 : k == 7 ? 8'h80 : 8'($urandom);
			o = lsse_op_t'(16 + (k < 6 ? k : $urandom % 6));
			x = shm(o, v, f);
			run(LSSE_OP_IMM_LOAD, 0, 0, 22, 0, {8'h00, v});
			run(o, 0, 0, 22, 22, 0);
			peek(22, v);
			check("shift value", v, x[7:0]);
			check("shift flags", sreg_out, x[15:8]);
			f = x[15:8];
		end
		run(LSSE_OP_REG_COPY, 0, 0, 23, 22, 0);
		peek(23, v);
		check("copy", v, x[7:0]);
		pair(0, q);
		run(LSSE_OP_PAIR_COPY, 0, 0, 24, 26, 0);
		peek(24, v);
		peek(25, d);
		check("pair copy", {d, v}, q);
		check("copy flags", sreg_out, f);
		report_and_stop();
	end
endmodule
`default_nettype wire

// file: lsse_map.svh
// Constant map for the load, store and shift execution unit
`ifndef LSSE_MAP_SVH
`define LSSE_MAP_SVH

// Pointer register pairs inside the register file (low byte index)
`define LSSE_PTR_A_LO    5'h1A
`define LSSE_PTR_B_LO    5'h1C
`define LSSE_PTR_C_LO    5'h1E
`define LSSE_PAIR_HI_BIT 5'h01

// Pointer selector codes
`define LSSE_PSEL_A      2'h0
`define LSSE_PSEL_B      2'h1
`define LSSE_PSEL_C      2'h2

// Target of a program memory read with no named register
`define LSSE_DEF_TARGET  5'h00

// Status register bit positions
`define LSSE_FLAG_C      0
`define LSSE_FLAG_Z      1
`define LSSE_FLAG_N      2
`define LSSE_FLAG_V      3'h3

// Reset values
`define LSSE_SREG_RESET  8'h00
`define LSSE_SP_RESET    16'h0000
`define LSSE_ADDR_RESET  16'h0000
`define LSSE_BYTE_RESET  8'h00
`define LSSE_IO_RESET    6'h00
`define LSSE_REG_RESET   5'h00
`define LSSE_BIT_RESET   3'h0

// Step values
`define LSSE_ONE16       16'h0001
`define LSSE_BIT0_MASK   8'h01

// Cycles per instruction class
`define LSSE_CYC_FAST    1
`define LSSE_CYC_MEM     2
`define LSSE_CYC_PMEM    3

`endif

// file: lsse_mem_model.sv
// Data, program and I/O memory behind the execution unit
`timescale 1ns/1ps
`default_nettype none
module lsse_mem_model
(
	input  wire logic        clk_in,      // Clock
	input  wire logic [15:0] d_addr_in,   // Data address
	input  wire logic [7:0]  d_wdata_in,  // Data in
	input  wire logic        d_re_in,     // Data read
	input  wire logic        d_we_in,     // Data write
	output logic      [7:0]  d_rdata_out, // Data out
	input  wire logic [15:0] p_addr_in,   // Program address
	input  wire logic        p_re_in,     // Program read
	output logic      [7:0]  p_rdata_out, // Program data
	input  wire logic [5:0]  i_addr_in,   // I/O address
	input  wire logic        i_re_in,     // I/O read
	input  wire logic        i_we_in,     // I/O write
	input  wire logic [7:0]  i_wdata_in,  // I/O data in
	output logic      [7:0]  i_rdata_out  // I/O data out
);
	logic [7:0] dmem [0:65535];
	logic [7:0] io [0:63];
	logic [7:0] d_q = 8'h00, i_q = 8'h00, p_q = 8'h00;
	logic       p_vld_q = 1'b0;
	// Unread lines toggle so stale data never looks valid
	assign d_rdata_out = d_re_in ? dmem[d_addr_in] : ~d_q;
	assign i_rdata_out = i_re_in ? io[i_addr_in] : ~i_q;
	assign p_rdata_out = p_vld_q ? p_q : ~p_q;
	always @(posedge clk_in)
	begin
		if (d_we_in)
			dmem[d_addr_in] <= d_wdata_in;
		if (i_we_in)
			io[i_addr_in] <= i_wdata_in;
		d_q <= d_rdata_out;
		i_q <= i_rdata_out;
		p_vld_q <= p_re_in;
		p_q <= p_re_in ? p_addr_in[7:0] ^ p_addr_in[15:8] ^ 8'h5A : p_rdata_out;
	end
endmodule
`default_nettype wire

// file: lsse_pkg.sv
// Types shared by the load, store and shift execution unit
package lsse_pkg;

	typedef enum logic [4:0]
	{
		LSSE_OP_NOP       = 5'h00,
		LSSE_OP_REG_COPY  = 5'h01,
		LSSE_OP_PAIR_COPY = 5'h02,
		LSSE_OP_IMM_LOAD  = 5'h03,
		LSSE_OP_IND_LOAD  = 5'h04,
		LSSE_OP_DIR_LOAD  = 5'h05,
		LSSE_OP_IND_WRITE = 5'h06,
		LSSE_OP_DIR_WRITE = 5'h07,
		LSSE_OP_PM_DEF    = 5'h08,
		LSSE_OP_PM_READ   = 5'h09,
		LSSE_OP_PM_INC    = 5'h0A,
		LSSE_OP_PUSH      = 5'h0B,
		LSSE_OP_POP       = 5'h0C,
		LSSE_OP_IO_SET    = 5'h0D,
		LSSE_OP_IO_CLR    = 5'h0E,
		LSSE_OP_IO_OUT    = 5'h0F,
		LSSE_OP_LSL       = 5'h10,
		LSSE_OP_LSR       = 5'h11,
		LSSE_OP_ROL       = 5'h12,
		LSSE_OP_ROR       = 5'h13,
		LSSE_OP_ASR       = 5'h14,
		LSSE_OP_SWAP      = 5'h15
	} lsse_op_t;

	typedef enum logic [1:0]
	{
		LSSE_AM_PLAIN   = 2'h0,
		LSSE_AM_POSTINC = 2'h1,
		LSSE_AM_PREDEC  = 2'h2,
		LSSE_AM_DISP    = 2'h3
	} lsse_amode_t;

	typedef enum logic [2:0]
	{
		LSSE_ST_IDLE  = 3'b001,
		LSSE_ST_PWAIT = 3'b010,
		LSSE_ST_LAST  = 3'b100
	} lsse_state_t;

endpackage
